// ### core/hs_clk_pkg.sv
// shared constants for the lane status and output clock control block
package hs_clk_pkg;
  // ----------------------------------------------------------------
  // register port geometry and offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_LANE_STATUS = 8'h14; // high_speed_lane_status
  localparam logic [7:0] OFS_CLK_CTRL = 8'h15; // clock_output_control
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c; // sticky event bits, read only
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1d; // write one to clear, write only
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1e; // event enables
  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int BIT_MAIN_OVERRUN = 0;
  localparam int BIT_MAIN_UNDERRUN = 1;
  localparam int BIT_ALT_OVERRUN = 2;
  localparam int BIT_ALT_UNDERRUN = 3;
  localparam int BIT_XMIT_LANE0 = 8;
  localparam int BIT_XMIT_LANE1 = 9;
  localparam int BIT_RECV_LANE0 = 10;
  localparam int BIT_RECV_LANE1 = 11;
  localparam int BIT_XMIT_LANE2 = 12;
  localparam int BIT_XMIT_LANE3 = 13;
  localparam int BIT_RECV_LANE2 = 14;
  localparam int BIT_RECV_LANE3 = 15;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // ----------------------------------------------------------------
  // clock control fields
  // ----------------------------------------------------------------
  localparam int BIT_GATE = 9;
  localparam int BIT_SLEEP = 8;
  localparam int RATIO_LSB = 4;
  localparam int SOURCE_LSB = 0;
  localparam logic [15:0] CLK_CTRL_RST = 16'h0280;
  localparam logic [15:0] CLK_CTRL_WMASK = 16'h03ff; // bits 15:10 always zero
  localparam logic [3:0] RATIO_DIV1 = 4'h0;
  localparam logic [3:0] RATIO_DIV4 = 4'h8;
  localparam logic [3:0] RATIO_DIV8 = 4'h9;
  localparam logic [3:0] RATIO_DIV16 = 4'ha;
  localparam logic [3:0] RATIO_DIV5 = 4'hc;
  // divider period counts, in edges of the selected source
  localparam int DIV_W = 5;
  localparam logic [4:0] PERIOD_4 = 5'h04;
  localparam logic [4:0] PERIOD_5 = 5'h05;
  localparam logic [4:0] PERIOD_8 = 5'h08;
  localparam logic [4:0] PERIOD_16 = 5'h10;
  // ----------------------------------------------------------------
  // clock source indices
  // ----------------------------------------------------------------
  localparam int N_SRC = 9;
  localparam logic [3:0] SRC_A_REC = 4'h0;
  localparam logic [3:0] SRC_A_XMIT = 4'h1;
  localparam logic [3:0] SRC_A_VCO4 = 4'h2;
  localparam logic [3:0] SRC_L03_REC = 4'h3;
  localparam logic [3:0] SRC_L03_XMIT = 4'h4;
  localparam logic [3:0] SRC_B_REC = 4'h5;
  localparam logic [3:0] SRC_B_XMIT = 4'h6;
  localparam logic [3:0] SRC_B_VCO4 = 4'h7;
  localparam logic [3:0] SRC_L47_REC = 4'h8;
  localparam logic [3:0] SRC_NONE = 4'hf;
endpackage

// ### core/pin_sync.sv
// two flip-flop synchroniser bank for inputs from foreign clock domains
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q; // first stage, read only by the second

  // first stage feeds the second stage and nothing else
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### core/clk_ratio_div.sv
// edge counting divider for the sampled output clock source
`timescale 1ns/10ps
module clk_ratio_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic src_rise,
  input wire logic src_level,
  input wire logic bypass,
  input wire logic [hs_clk_pkg::DIV_W-1:0] period,
  output logic div_level
);
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [hs_clk_pkg::DIV_W-1:0] cnt_q; // source edges within one period
  logic [hs_clk_pkg::DIV_W-1:0] cnt_d;
  logic wrap; // last edge of the period, or stale count after a change
  logic [hs_clk_pkg::DIV_W-1:0] half; // high time, rounded up for odd periods

  assign wrap = (cnt_q >= period - 5'h01);
  assign cnt_d = wrap ? 5'h00 : cnt_q + 5'h01;
  assign half = (period + 5'h01) >> 1;

  // count only on source edges, so the output period is period source edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce && src_rise && !bypass) begin
      cnt_q <= cnt_d;
    end
  end

  // divide by one passes the sampled source straight through
  assign div_level = bypass ? src_level : (cnt_q < half);
endmodule

// ### core/hs_status_clk_ctrl.sv
// lane status register, event interrupt and output clock control
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module hs_status_clk_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [hs_clk_pkg::ADDR_W-1:0] addr,
  input wire logic [hs_clk_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [hs_clk_pkg::DATA_W-1:0] rd_data,
  input wire logic [3:0] recv_lane_aligned,
  input wire logic [3:0] xmit_lane_aligned,
  input wire logic main_macro_rxq_overrun,
  input wire logic main_macro_rxq_underrun,
  input wire logic alt_macro_rxq_overrun,
  input wire logic alt_macro_rxq_underrun,
  input wire logic alt_macro_selected,
  input wire logic [hs_clk_pkg::N_SRC-1:0] src_clocks,
  output logic diff_clock_output_p,
  output logic diff_clock_output_n,
  output logic irq
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q; // first stage of the reset release
  logic rst_n; // synchronised reset used by all logic

  // assert at once, release two edges later so no flop sees a runt release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // map the four-bit source field to a source index, or none
  function automatic logic [3:0] source_index(input logic [3:0] code);
    logic [3:0] idx;
    idx = hs_clk_pkg::SRC_NONE;
    unique casez (code)
      4'b00?0: idx = hs_clk_pkg::SRC_A_REC;
      4'b00?1: idx = hs_clk_pkg::SRC_A_XMIT;
      4'b010?: idx = hs_clk_pkg::SRC_A_VCO4;
      4'b0110: idx = hs_clk_pkg::SRC_L03_REC;
      4'b0111: idx = hs_clk_pkg::SRC_L03_XMIT;
      4'b10?0: idx = hs_clk_pkg::SRC_B_REC;
      4'b10?1: idx = hs_clk_pkg::SRC_B_XMIT;
      4'b110?: idx = hs_clk_pkg::SRC_B_VCO4;
      4'b1110: idx = hs_clk_pkg::SRC_L47_REC;
      4'b1111: idx = hs_clk_pkg::SRC_NONE;
    endcase
    return idx;
  endfunction

  // map the ratio field to a period; zero period means reserved
  function automatic logic [hs_clk_pkg::DIV_W-1:0] ratio_period(input logic [3:0] code);
    logic [hs_clk_pkg::DIV_W-1:0] p;
    p = 5'h00; // reserved and unresolved codes
    if (code == hs_clk_pkg::RATIO_DIV1) begin
      p = 5'h01;
    end else if (code == hs_clk_pkg::RATIO_DIV4) begin
      p = hs_clk_pkg::PERIOD_4;
    end else if (code == hs_clk_pkg::RATIO_DIV8) begin
      p = hs_clk_pkg::PERIOD_8;
    end else if (code == hs_clk_pkg::RATIO_DIV16) begin
      p = hs_clk_pkg::PERIOD_16;
    end else if (code == hs_clk_pkg::RATIO_DIV5) begin
      p = hs_clk_pkg::PERIOD_5;
    end
    return p;
  endfunction

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire hit_status = (addr == hs_clk_pkg::OFS_LANE_STATUS);
  wire hit_ctrl = (addr == hs_clk_pkg::OFS_CLK_CTRL);
  wire hit_irq_stat = (addr == hs_clk_pkg::OFS_IRQ_STATUS);
  wire hit_irq_clr = (addr == hs_clk_pkg::OFS_IRQ_CLEAR);
  wire hit_irq_en = (addr == hs_clk_pkg::OFS_IRQ_ENABLE);
  wire status_read = ce && rd_en && hit_status; // read that clears latched bits
  wire ctrl_write = ce && wr_en && hit_ctrl;
  wire irq_clear_write = ce && wr_en && hit_irq_clr;
  wire irq_en_write = ce && wr_en && hit_irq_en;

  // ----------------------------------------------------------------
  // status conditions in register layout
  // ----------------------------------------------------------------
  logic [15:0] cond; // live conditions, same clock, no sampling needed
  always_comb begin
    cond = hs_clk_pkg::STATUS_RST;
    cond[hs_clk_pkg::BIT_RECV_LANE0] = recv_lane_aligned[0];
    cond[hs_clk_pkg::BIT_RECV_LANE1] = recv_lane_aligned[1];
    cond[hs_clk_pkg::BIT_RECV_LANE2] = recv_lane_aligned[2];
    cond[hs_clk_pkg::BIT_RECV_LANE3] = recv_lane_aligned[3];
    cond[hs_clk_pkg::BIT_XMIT_LANE0] = xmit_lane_aligned[0];
    cond[hs_clk_pkg::BIT_XMIT_LANE1] = xmit_lane_aligned[1];
    cond[hs_clk_pkg::BIT_XMIT_LANE2] = xmit_lane_aligned[2];
    cond[hs_clk_pkg::BIT_XMIT_LANE3] = xmit_lane_aligned[3];
    cond[hs_clk_pkg::BIT_MAIN_OVERRUN] = main_macro_rxq_overrun;
    cond[hs_clk_pkg::BIT_MAIN_UNDERRUN] = main_macro_rxq_underrun;
    // alternate queue only counts while its data path is in use
    cond[hs_clk_pkg::BIT_ALT_OVERRUN] = alt_macro_selected && alt_macro_rxq_overrun;
    cond[hs_clk_pkg::BIT_ALT_UNDERRUN] = alt_macro_selected && alt_macro_rxq_underrun;
  end

  // ----------------------------------------------------------------
  // latched status register
  // ----------------------------------------------------------------
  logic [15:0] status_q; // high_speed_lane_status
  logic [15:0] status_d;
  // a live condition wins over the clearing read, so no event is lost
  assign status_d = cond | (status_read ? 16'h0000 : status_q);

  // latched bits hold until read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= hs_clk_pkg::STATUS_RST;
    end else if (ce) begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // clock control register
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q; // clock_output_control
  logic [15:0] ctrl_d;
  // top bits are never stored, so they always read back as zero
  assign ctrl_d = ctrl_write ? (wr_data & hs_clk_pkg::CLK_CTRL_WMASK) : ctrl_q;

  // software settings; reset gives gate on, divide by four, source 0000
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= hs_clk_pkg::CLK_CTRL_RST;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  wire out_clock_gate = ctrl_q[hs_clk_pkg::BIT_GATE];
  wire out_clock_sleep = ctrl_q[hs_clk_pkg::BIT_SLEEP];
  wire [3:0] out_clock_ratio = ctrl_q[hs_clk_pkg::RATIO_LSB +: 4];
  wire [3:0] out_clock_source = ctrl_q[hs_clk_pkg::SOURCE_LSB +: 4];

  // ----------------------------------------------------------------
  // interrupt: sticky events, enable, write-one clear
  // ----------------------------------------------------------------
  logic [15:0] cond_prev_q; // conditions one cycle ago, for rise detection
  logic [15:0] irq_stat_q;
  logic [15:0] irq_stat_d;
  logic [15:0] irq_en_q;
  wire [15:0] cond_rise = cond & ~cond_prev_q;
  wire [15:0] irq_clr_bits = irq_clear_write ? wr_data : 16'h0000;
  // a new event in the cycle of its clear keeps the bit set
  assign irq_stat_d = cond_rise | (irq_stat_q & ~irq_clr_bits);
  wire irq_d = |(irq_stat_d & irq_en_q);

  // event capture, enables and the registered interrupt line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_prev_q <= 16'h0000;
      irq_stat_q <= 16'h0000;
      irq_en_q <= 16'h0000;
      irq <= 1'b0;
    end else if (ce) begin
      cond_prev_q <= cond;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_write ? wr_data : irq_en_q;
      irq <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // read data, valid in the cycle after the read strobe only
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000; // unmapped and write-only offsets read zero
    if (hit_status) begin
      rd_mux = status_q;
    end else if (hit_ctrl) begin
      rd_mux = ctrl_q;
    end else if (hit_irq_stat) begin
      rd_mux = irq_stat_q;
    end else if (hit_irq_en) begin
      rd_mux = irq_en_q;
    end
  end

  // data is dropped to zero outside the answer cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= rd_en ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // source sampling and selection
  // ----------------------------------------------------------------
  logic [hs_clk_pkg::N_SRC-1:0] src_sync; // sources after two flops
  pin_sync #(.W(hs_clk_pkg::N_SRC)) u_src_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(src_clocks),
    .q(src_sync)
  );

  wire [3:0] src_idx = source_index(out_clock_source);
  wire src_valid = (src_idx != hs_clk_pkg::SRC_NONE);
  // only the selected source reaches the divider
  wire src_level = src_valid ? src_sync[src_idx] : 1'b0;
  logic src_prev_q; // selected level one cycle ago
  wire src_rise = src_level && !src_prev_q;

  // edge detector on the selected, already synchronised source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= 1'b0;
    end else if (ce) begin
      src_prev_q <= src_level;
    end
  end

  // ----------------------------------------------------------------
  // divider and output stage
  // ----------------------------------------------------------------
  // limitation: sources are sampled at 25 MHz, so a source must run
  // well below half that rate to be reproduced faithfully
  wire [hs_clk_pkg::DIV_W-1:0] period = ratio_period(out_clock_ratio);
  wire ratio_valid = (period != 5'h00);
  logic div_level;
  clk_ratio_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .src_rise(src_rise),
    .src_level(src_level),
    .bypass(period == 5'h01),
    .period(period),
    .div_level(div_level)
  );

  // reserved codes and a closed gate both park the output low
  wire run = out_clock_gate && src_valid && ratio_valid;
  wire level = run && div_level;
  wire out_p_d = out_clock_sleep ? 1'b0 : level;
  wire out_n_d = out_clock_sleep ? 1'b0 : !level;

  // output pair straight from flops; sleep drives both legs low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diff_clock_output_p <= 1'b0;
      diff_clock_output_n <= 1'b0;
    end else if (ce) begin
      diff_clock_output_p <= out_p_d;
      diff_clock_output_n <= out_n_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_status_read;
    rd_en && hit_status;
  endsequence
  // no live condition in the cycle of the read, so nothing may survive it
  sequence s_cond_gone;
    (cond == 16'h0000);
  endsequence

  a_latch_holds: assert property (
    (cond == 16'h0000) && !status_read |=> status_q == $past(status_q))
    else $error("latched status changed without cause");
  a_read_clears: assert property (
    s_status_read ##0 s_cond_gone |=> status_q == 16'h0000)
    else $error("status not cleared by read");
  a_recv_align: assert property (
    recv_lane_aligned[2] |=> status_q[hs_clk_pkg::BIT_RECV_LANE2])
    else $error("receive lane 2 alignment not latched");
  a_xmit_align: assert property (
    xmit_lane_aligned[1] |=> status_q[hs_clk_pkg::BIT_XMIT_LANE1])
    else $error("transmit lane 1 alignment not latched");
  a_main_overrun: assert property (
    main_macro_rxq_overrun |=> status_q[hs_clk_pkg::BIT_MAIN_OVERRUN])
    else $error("main overrun not latched");
  a_main_underrun: assert property (
    main_macro_rxq_underrun |=> status_q[hs_clk_pkg::BIT_MAIN_UNDERRUN])
    else $error("main underrun not latched");
  a_alt_latch: assert property (
    alt_macro_selected && alt_macro_rxq_overrun |=> status_q[hs_clk_pkg::BIT_ALT_OVERRUN])
    else $error("alternate overrun not latched while selected");
  // the enable must hold ctrl_q and status_q, so this one ignores the default disable
  a_ce_freeze: assert property (
    disable iff (!rst_n) !ce |=> $stable(ctrl_q) && $stable(status_q))
    else $error("register changed while clock enable low");
  a_alt_gated: assert property (
    !status_q[hs_clk_pkg::BIT_ALT_UNDERRUN] && !alt_macro_selected
    |=> !status_q[hs_clk_pkg::BIT_ALT_UNDERRUN])
    else $error("alternate underrun set while not selected");
  a_top_zero: assert property (
    rd_en && hit_ctrl |=> rd_data[15:10] == 6'h00)
    else $error("reserved control bits read nonzero");
  a_gate_fixed: assert property (
    !out_clock_gate && !out_clock_sleep && $stable(ctrl_q)
    |=> diff_clock_output_p == 1'b0 && diff_clock_output_n == 1'b1)
    else $error("gated output not fixed");
  a_sleep_low: assert property (
    out_clock_sleep |=> !diff_clock_output_p && !diff_clock_output_n)
    else $error("sleeping output still driven");
  a_reserved_park: assert property (
    !ratio_valid && !out_clock_sleep |=> !diff_clock_output_p)
    else $error("reserved ratio did not park output");
endmodule

// ### verif/hs_status_clk_ctrl_bench.sv
// self-checking bench for the lane status and output clock control block
`timescale 1ns/10ps
module hs_status_clk_ctrl_bench;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] recv = 4'h0;
  logic [3:0] xmit = 4'h0;
  logic [3:0] fifo = 4'h0; // main over, main under, alt over, alt under
  logic alt_sel = 1'b0;
  logic [8:0] src = 9'h000;
  logic [8:0] src_mask = 9'h000; // sources that toggle
  logic [1:0] src_cnt = 2'h0;
  logic [15:0] rd_data;
  logic p, n, irq;
  logic [15:0] seed = 16'h6508; // lfsr start value
  logic [15:0] d, e;
  int per, i, n_fail = 0, comparisons = 0;
  logic [3:0] ratio_tab [5] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hc};
  int per_tab [5] = '{8, 32, 64, 128, 40};
  hs_status_clk_ctrl uut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .recv_lane_aligned(recv), .xmit_lane_aligned(xmit),
    .main_macro_rxq_overrun(fifo[0]), .main_macro_rxq_underrun(fifo[1]),
    .alt_macro_rxq_overrun(fifo[2]), .alt_macro_rxq_underrun(fifo[3]),
    .alt_macro_selected(alt_sel), .src_clocks(src), .diff_clock_output_p(p),
    .diff_clock_output_n(n), .irq(irq));
  // ------------------------------------------------------------
  // clocks: system clock and slow foreign sources (8 cycle period)
  // ------------------------------------------------------------
  always #20 clk = ~clk;
  always @(posedge clk) begin
    src_cnt <= src_cnt + 2'h1;
    if (src_cnt == 2'h3) begin
      src <= src ^ src_mask; // only selected sources move, so a wrong mux stalls
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // expected latched status from one cycle of conditions
  function automatic logic [15:0] stat_of(input logic [3:0] r, input logic [3:0] x,
    input logic [3:0] f, input logic s);
    return {r[3], r[2], x[3], x[2], r[1], r[0], x[1], x[0], 4'h0, f[3] & s, f[2] & s,
      f[1], f[0]};
  endfunction
  // source index that a select code routes out
  function automatic int src_of(input logic [3:0] c);
    if (c[3:2] == 2'b00) return c[0] ? 1 : 0;
    if (c[3:1] == 3'b010) return 2;
    if (c[3:1] == 3'b011) return c[0] ? 4 : 3;
    if (c[3:2] == 2'b10) return c[0] ? 6 : 5;
    if (c[3:1] == 3'b110) return 7;
    return 8;
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_per(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // period of p in system cycles, 0 when it stalls
  task automatic measure(output int pr);
    int k;
    k = 0;
    pr = 0;
    while (p !== 1'b0 && k < 400) begin tick(); k++; end
    while (p !== 1'b1 && k < 400) begin tick(); k++; end
    while (p !== 1'b0 && k < 400) begin tick(); k++; pr++; end
    while (p !== 1'b1 && k < 400) begin tick(); k++; pr++; end
    if (k >= 400) pr = 0;
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    #(40 * 30000);
    n_fail++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) tick();
    rd(8'h14, d); chk_w(d, 16'h0000);
    tick(); chk_w(rd_data, 16'h0000); // read data stands one cycle only
    rd(8'h15, d); chk_w(d, 16'h0280);
    rd(8'h03, d); chk_w(d, 16'h0000);
    wr(8'h14, 16'hffff);
    rd(8'h14, d); chk_w(d, 16'h0000);
    wr(8'h15, 16'hffff);
    rd(8'h15, d); chk_w(d, 16'h03ff);
    // random one-cycle events, then read, clear and interrupt
    for (i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      // expectation from the drawn bits, even when none of them is set
      e = stat_of(seed[3:0], seed[7:4], seed[11:8], seed[12]);
      @(posedge clk);
      {alt_sel, fifo, xmit, recv} <= seed[12:0];
      @(posedge clk);
      {fifo, xmit, recv} <= 12'h000;
      seed = lfsr(seed);
      wr(8'h1e, seed);
      rd(8'h14, d); chk_w(d, e);
      chk_w({15'h0, irq}, {15'h0, |(e & seed)});
      rd(8'h1e, d); chk_w(d, seed);
      rd(8'h1c, d); chk_w(d, e);
      rd(8'h14, d); chk_w(d, 16'h0000);
      wr(8'h1d, 16'hffff);
      rd(8'h1c, d); chk_w(d, 16'h0000);
      chk_w({15'h0, irq}, 16'h0000);
    end
    // a live condition survives the clearing read
    @(posedge clk);
    recv <= 4'h1;
    rd(8'h14, d); chk_w(d, 16'h0400);
    rd(8'h14, d); chk_w(d, 16'h0400);
    @(posedge clk);
    recv <= 4'h0;
    rd(8'h14, d); chk_w(d, 16'h0400);
    rd(8'h14, d); chk_w(d, 16'h0000);
    // every select code except 1111 routes its own source at divide by one
    for (i = 0; i < 15; i++) begin
      src_mask = 9'h001 << src_of(i[3:0]);
      wr(8'h15, 16'h0200 | i[15:0]);
      measure(per);
      measure(per); chk_per(per, 8);
    end
    // divider codes on source 0
    src_mask = 9'h001;
    for (i = 0; i < 5; i++) begin
      wr(8'h15, {6'h00, 2'b10, ratio_tab[i], 4'h0});
      measure(per);
      measure(per); chk_per(per, per_tab[i]);
      chk_w({15'h0, n}, {15'h0, ~p});
    end
    // gate off, sleep, reserved source and reserved ratio
    src_mask = 9'h1ff;
    for (i = 0; i < 4; i++) begin
      e = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0300 : (i == 2) ? 16'h020f : 16'h0210;
      wr(8'h15, e);
      repeat (6) tick();
      repeat (12) begin
        tick();
        chk_w({14'h0, p, n}, (i == 1) ? 16'h0000 : 16'h0001);
      end
    end
    // a write while the clock enable is low must leave the control word alone
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h15, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h15, d); chk_w(d, 16'h0210);
    report_and_stop();
  end
endmodule
